// [cfg_decoder_defs.svh]
`ifndef CFG_DECODER_DEFS_SVH
`define CFG_DECODER_DEFS_SVH

// register byte offsets on the APB slave
`define OFS_WORD_ONE   8'h00
`define OFS_WORD_THREE 8'h04
`define OFS_CTRL       8'h08
`define OFS_STATUS     8'h0C

// first word field positions
`define W1_WINSZ_LSB   24
`define W1_HARD_EN     23
`define W1_WDT_WINDOW_DISABLE      22
`define W1_PS_LSB      16
`define W1_CKSM_LSB    14
`define W1_PBDIV_LSB   12
`define W1_CLOCK_OUTPUT_DIS    10
`define W1_POSC_LSB    8
`define W1_TWO_SPEED   7
`define W1_SOSC_EN     5
`define W1_OSC_LSB     0

// third word field positions
`define W3_BUS_PWR     31
`define W3_USB_ID      30
`define W3_PPS_ONCE    29
`define W3_PMD_ONCE    28
`define W3_UID_LSB     0
`define W3_IMPL_MASK   32'hF000FFFF

// postscale limit and window fractions in eighths
`define PS_MAX         5'h14
`define WIN_25         3'h2
`define WIN_37         3'h3
`define WIN_50         3'h4
`define WIN_75         3'h6

// control and status layout
`define CTRL_WDT_SW    0
`define ST_LOADED      0
`define ST_WDT_RUN     1
`define ST_PPS_LOCK    2
`define ST_PMD_LOCK    3

`endif

// [cfg_decoder_pkg.sv]
`default_nettype none
package cfg_decoder_pkg;

  typedef enum logic [2:0] {
    SRC_FAST_RC, SRC_FAST_RC_DIV_PLL, SRC_PRIMARY, SRC_PRIMARY_PLL,
    SRC_SECONDARY, SRC_LOW_POWER_RC, SRC_FAST_RC_DIV16, SRC_FAST_RC_DIV_N
  } osc_src_t;

  typedef enum logic [1:0] {
    POSC_EXTERNAL, POSC_STD_CRYSTAL, POSC_HS_CRYSTAL, POSC_OFF
  } posc_mode_t;

  typedef struct packed {
    logic       enable;
    logic       hard_on;
    logic       window_en;
    logic [2:0] window_eighths;
    logic [4:0] postscale_exp;
  } wdt_cfg_t;

  typedef struct packed {
    osc_src_t   source;
    posc_mode_t posc_mode;
    logic       two_speed;
    logic       sosc_en;
    logic       switch_en;
    logic       monitor_en;
    logic [3:0] pb_divisor;
    logic       clk_out_en;
  } clk_cfg_t;

  typedef struct packed {
    logic bus_power_usb;
    logic usb_ident_usb;
    logic pps_write_ok;
    logic pmd_write_ok;
  } pin_cfg_t;

endpackage : cfg_decoder_pkg
`default_nettype wire

// [device_config_word_decoder.sv]
// Notes on behaviour
// - window size code picks open fraction
// - hard enable forces watchdog on
// - window disable bit selects non-window
// - postscale code is power-of-two exponent
// - postscale above 10100 acts as 10100
// - clock switch and monitor decode
// - bus divisor default 1,2,4,8
// - clock out only when mode 11/00
// - primary oscillator mode decode
// - bit 7 enables two-speed start-up
// - bit 5 enables secondary oscillator
// - oscillator source field selects clock
// - bit 31 bus-power pin to USB
// - bit 30 ident pin to USB
// - pin map reconfigured once if set
// - module disable changed once if set
// - 16-bit identifier held and readable
// - third word bits 27-16 read zero
`include "cfg_decoder_defs.svh"
`default_nettype none
module device_config_word_decoder (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [31:0]              nv_word_one,
  input  wire logic [31:0]              nv_word_three,
  input  wire logic                     pin_map_reconfig,
  input  wire logic                     module_dis_reconfig,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  output cfg_decoder_pkg::wdt_cfg_t     wdt_cfg,
  output cfg_decoder_pkg::clk_cfg_t     clk_cfg,
  output cfg_decoder_pkg::pin_cfg_t     pin_cfg,
  output logic [15:0]                   user_identifier,
  output logic                          cfg_loaded
);

  logic [31:0] word_one_r;
  logic [31:0] word_three_r;
  logic        loaded_r;
  logic        wdt_sw_r;
  logic        pps_done_r;
  logic        pmd_done_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  cfg_decoder_pkg::wdt_cfg_t wdt_r;
  cfg_decoder_pkg::clk_cfg_t clk_r;
  cfg_decoder_pkg::pin_cfg_t pin_r;
  cfg_decoder_pkg::wdt_cfg_t wdt_nxt;
  cfg_decoder_pkg::clk_cfg_t clk_nxt;
  logic        acc;
  logic        wr_ctrl;

  // raw field views of the incoming first word
  logic [1:0]  winsz;
  logic [4:0]  ps;
  logic [1:0]  cksm;
  logic [1:0]  pbdiv;
  logic [1:0]  posc;
  logic [2:0]  osc;

  assign winsz = nv_word_one[`W1_WINSZ_LSB +: 2];
  assign ps    = nv_word_one[`W1_PS_LSB +: 5];
  assign cksm  = nv_word_one[`W1_CKSM_LSB +: 2];
  assign pbdiv = nv_word_one[`W1_PBDIV_LSB +: 2];
  assign posc  = nv_word_one[`W1_POSC_LSB +: 2];
  assign osc   = nv_word_one[`W1_OSC_LSB +: 3];

  assign acc     = psel && penable && pready_r;
  assign wr_ctrl = acc && pwrite && (paddr == `OFS_CTRL);

  // watchdog field decode from the incoming first word
  always_comb
  begin
    wdt_nxt = '0;
    case (winsz)
      2'h3:    wdt_nxt.window_eighths = `WIN_25;
      2'h2:    wdt_nxt.window_eighths = `WIN_37;
      2'h1:    wdt_nxt.window_eighths = `WIN_50;
      default: wdt_nxt.window_eighths = `WIN_75;
    endcase
    wdt_nxt.hard_on   = nv_word_one[`W1_HARD_EN];
    wdt_nxt.enable    = nv_word_one[`W1_HARD_EN];
    wdt_nxt.window_en = !nv_word_one[`W1_WDT_WINDOW_DISABLE];
    if (ps > `PS_MAX)
      wdt_nxt.postscale_exp = `PS_MAX;
    else
      wdt_nxt.postscale_exp = ps;
  end

  // clock field decode from the incoming first word
  always_comb
  begin
    clk_nxt = '0;
    clk_nxt.source     = cfg_decoder_pkg::osc_src_t'(osc);
    clk_nxt.posc_mode  = cfg_decoder_pkg::posc_mode_t'(posc);
    clk_nxt.two_speed  = nv_word_one[`W1_TWO_SPEED];
    clk_nxt.sosc_en    = nv_word_one[`W1_SOSC_EN];
    clk_nxt.switch_en  = !cksm[1];
    clk_nxt.monitor_en = (cksm == 2'h0);
    case (pbdiv)
      2'h0:    clk_nxt.pb_divisor = 4'h1;
      2'h1:    clk_nxt.pb_divisor = 4'h2;
      2'h2:    clk_nxt.pb_divisor = 4'h4;
      default: clk_nxt.pb_divisor = 4'h8;
    endcase
    // primary off with primary source is left as programmed
    clk_nxt.clk_out_en = !nv_word_one[`W1_CLOCK_OUTPUT_DIS]
                         && (posc == 2'h3 || posc == 2'h0);
  end

  // one capture of both words at the first edge after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loaded_r     <= 1'b0;
      word_one_r   <= 32'h0;
      word_three_r <= 32'h0;
      clk_r        <= '0;
    end
    else if (!loaded_r)
    begin
      loaded_r     <= 1'b1;
      word_one_r   <= nv_word_one;
      word_three_r <= nv_word_three & `W3_IMPL_MASK;
      clk_r        <= clk_nxt;
    end
  end

  // watchdog settings; software may only add an enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_r <= '0;
    else if (!loaded_r)
      wdt_r <= wdt_nxt;
    else
      wdt_r.enable <= wdt_r.hard_on || wdt_sw_r;
  end

  // software watchdog enable bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_sw_r <= 1'b0;
    else if (wr_ctrl)
      wdt_sw_r <= pwdata[`CTRL_WDT_SW];
  end

  // lock-once tracking; a reconfiguration event is sticky
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pps_done_r <= 1'b0;
      pmd_done_r <= 1'b0;
    end
    else if (loaded_r)
    begin
      if (pin_map_reconfig)
        pps_done_r <= 1'b1;
      if (module_dis_reconfig)
        pmd_done_r <= 1'b1;
    end
  end

  // pin ownership and write permission
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_r <= '0;
    else if (!loaded_r)
    begin
      pin_r.bus_power_usb <= nv_word_three[`W3_BUS_PWR];
      pin_r.usb_ident_usb <= nv_word_three[`W3_USB_ID];
      pin_r.pps_write_ok  <= 1'b1;
      pin_r.pmd_write_ok  <= 1'b1;
    end
    else
    begin
      pin_r.pps_write_ok <= !(word_three_r[`W3_PPS_ONCE]
                             && (pps_done_r || pin_map_reconfig));
      pin_r.pmd_write_ok <= !(word_three_r[`W3_PMD_ONCE]
                             && (pmd_done_r || module_dis_reconfig));
    end
  end

  // apb slave: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= psel && !penable;
      if (psel && !penable)
      begin
        prdata_r  <= 32'h0;
        pslverr_r <= 1'b0;
        case (paddr)
          `OFS_WORD_ONE:
          begin
            prdata_r  <= pwrite ? 32'h0 : word_one_r;
            pslverr_r <= pwrite;
          end
          `OFS_WORD_THREE:
          begin
            prdata_r  <= pwrite ? 32'h0 : word_three_r;
            pslverr_r <= pwrite;
          end
          `OFS_CTRL:
            prdata_r[`CTRL_WDT_SW] <= pwrite ? 1'b0 : wdt_sw_r;
          `OFS_STATUS:
          begin
            pslverr_r <= pwrite;
            if (!pwrite)
            begin
              prdata_r[`ST_LOADED]   <= loaded_r;
              prdata_r[`ST_WDT_RUN]  <= wdt_r.enable;
              prdata_r[`ST_PPS_LOCK] <= !pin_r.pps_write_ok;
              prdata_r[`ST_PMD_LOCK] <= !pin_r.pmd_write_ok;
            end
          end
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign wdt_cfg         = wdt_r;
  assign clk_cfg         = clk_r;
  assign pin_cfg         = pin_r;
  assign user_identifier = word_three_r[`W3_UID_LSB +: 16];
  assign cfg_loaded      = loaded_r;

  // checks on the decoded settings
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load;
    !loaded_r ##1 loaded_r;
  endsequence

  a_window_fraction: assert property (
    loaded_r |-> (word_one_r[25:24] == 2'h3 ? wdt_r.window_eighths == `WIN_25 :
                  word_one_r[25:24] == 2'h2 ? wdt_r.window_eighths == `WIN_37 :
                  word_one_r[25:24] == 2'h1 ? wdt_r.window_eighths == `WIN_50 :
                  wdt_r.window_eighths == `WIN_75))
    else $error("window fraction mismatch");

  a_hard_enable_on: assert property (
    loaded_r && word_one_r[`W1_HARD_EN] ##1 1'b1 |-> wdt_r.enable)
    else $error("hard-enabled watchdog turned off");

  a_window_mode: assert property (
    loaded_r |-> wdt_r.window_en == !word_one_r[`W1_WDT_WINDOW_DISABLE])
    else $error("window mode mismatch");

  a_postscale_clamp: assert property (
    loaded_r |-> wdt_r.postscale_exp == ((word_one_r[20:16] > `PS_MAX) ?
                 `PS_MAX : word_one_r[20:16]))
    else $error("postscale exponent wrong");

  a_switch_monitor: assert property (
    loaded_r |-> clk_r.monitor_en == (word_one_r[15:14] == 2'h0)
                 && clk_r.switch_en == !word_one_r[15])
    else $error("switch and monitor decode wrong");

  a_pb_divisor: assert property (
    loaded_r |-> clk_r.pb_divisor == (4'h1 << word_one_r[13:12]))
    else $error("peripheral bus divisor wrong");

  a_clock_out_gate: assert property (
    clk_r.clk_out_en |-> clk_r.posc_mode inside
      {cfg_decoder_pkg::POSC_OFF, cfg_decoder_pkg::POSC_EXTERNAL})
    else $error("clock out with crystal running");

  a_upper_zero: assert property (
    word_three_r[27:16] == 12'h0)
    else $error("unimplemented bits not zero");

  a_pps_once: assert property (
    loaded_r && word_three_r[`W3_PPS_ONCE] && pin_map_reconfig
    |=> !pin_cfg.pps_write_ok [*2])
    else $error("pin map not locked after reconfig");

  a_static_words: assert property (
    s_load |=> $stable(word_one_r) && $stable(clk_r) && $stable(word_three_r))
    else $error("configuration changed after load");

  // apb phases as the slave sees them
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_ready_pulse: assert property (
    s_setup |=> s_answer)
    else $error("ready not a single pulse after setup");

  a_refused_write: assert property (
    pready && pwrite && paddr != `OFS_CTRL |-> pslverr)
    else $error("write to read-only offset accepted");

  a_sw_enable: assert property (
    loaded_r && $past(loaded_r) |-> wdt_r.enable == (wdt_r.hard_on || $past(wdt_sw_r)))
    else $error("watchdog enable not hard or software");

  a_postscale_pass: assert property (
    loaded_r && word_one_r[20:16] <= `PS_MAX |-> wdt_r.postscale_exp == word_one_r[20:16])
    else $error("postscale exponent not passed through");

  a_source_mode: assert property (
    loaded_r |-> clk_r.source == word_one_r[`W1_OSC_LSB +: 3])
    else $error("oscillator source decode wrong");

  a_posc_mode: assert property (
    loaded_r |-> clk_r.posc_mode == word_one_r[`W1_POSC_LSB +: 2])
    else $error("primary oscillator mode decode wrong");

  a_two_speed: assert property (
    loaded_r |-> clk_r.two_speed == word_one_r[`W1_TWO_SPEED])
    else $error("two-speed start-up bit wrong");

  a_sosc_bit: assert property (
    loaded_r |-> clk_r.sosc_en == word_one_r[`W1_SOSC_EN])
    else $error("secondary oscillator enable wrong");

  a_clock_out_decode: assert property (
    loaded_r |-> clk_r.clk_out_en == (!word_one_r[`W1_CLOCK_OUTPUT_DIS]
                 && (word_one_r[9:8] == 2'h3 || word_one_r[9:8] == 2'h0)))
    else $error("clock output enable decode wrong");

  a_pin_owner: assert property (
    loaded_r |-> pin_cfg.bus_power_usb == word_three_r[`W3_BUS_PWR])
    else $error("bus power pin owner wrong");

  a_ident_owner: assert property (
    loaded_r |-> pin_cfg.usb_ident_usb == word_three_r[`W3_USB_ID])
    else $error("ident pin owner wrong");

  a_pmd_once: assert property (
    loaded_r && word_three_r[`W3_PMD_ONCE] && module_dis_reconfig
    |=> (!pin_cfg.pmd_write_ok) [*2])
    else $error("module disable not locked after change");

  a_pps_stays_open: assert property (
    loaded_r && !word_three_r[`W3_PPS_ONCE] |=> pin_cfg.pps_write_ok)
    else $error("pin map locked without lock-once");

  a_pmd_stays_open: assert property (
    loaded_r && !word_three_r[`W3_PMD_ONCE] |=> pin_cfg.pmd_write_ok)
    else $error("module disable locked without lock-once");

  a_words_frozen: assert property (
    loaded_r |=> $stable(word_one_r) && $stable(word_three_r) && $stable(clk_r)
                 && $stable(pin_cfg.bus_power_usb) && $stable(wdt_r.postscale_exp))
    else $error("loaded settings moved at run time");

endmodule : device_config_word_decoder
`default_nettype wire

// [nv_store_model.sv]
`default_nettype none
module nv_store_model (
  input  wire logic        pclk,
  input  wire logic [31:0] raw_one,
  input  wire logic [31:0] raw_three,
  input  wire logic        pin_req,
  input  wire logic        mod_req,
  output logic      [31:0] word_one,
  output logic      [31:0] word_three,
  output logic             pin_pulse,
  output logic             mod_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // programmed image: reserved positions set, primary kept on for primary source
  always_comb
  begin
    word_one = raw_one | 32'hFC200858;
    if (word_one[2:0] == 3'h2 && word_one[9:8] == 2'h3)
    begin
      word_one[9:8] = 2'h2;
    end
    word_three = raw_three;
  end
  // reconfiguration events from the pin-map and module-disable blocks
  always_ff @(posedge pclk)
  begin
    pin_pulse <= pin_req;
    mod_pulse <= mod_req;
  end
endmodule : nv_store_model
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       pclk, presetn, psel, penable, pwrite, pin_req, mod_req;
  logic                       pready, pslverr, pin_p, mod_p, cfg_loaded, e;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata, prdata, raw1, raw3, nv1, nv3, q, r;
  logic [15:0]                uid;
  cfg_decoder_pkg::wdt_cfg_t  wdt_cfg;
  cfg_decoder_pkg::clk_cfg_t  clk_cfg;
  cfg_decoder_pkg::pin_cfg_t  pin_cfg;
  int                         error_cnt, check_count;

  nv_store_model store (.pclk(pclk), .raw_one(raw1), .raw_three(raw3), .pin_req(pin_req),
    .mod_req(mod_req), .word_one(nv1), .word_three(nv3), .pin_pulse(pin_p),
    .mod_pulse(mod_p));
  device_config_word_decoder uut (.pclk(pclk), .presetn(presetn), .nv_word_one(nv1),
    .nv_word_three(nv3), .pin_map_reconfig(pin_p), .module_dis_reconfig(mod_p),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_cfg(wdt_cfg),
    .clk_cfg(clk_cfg), .pin_cfg(pin_cfg), .user_identifier(uid), .cfg_loaded(cfg_loaded));

  // 125 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // watchdog decode from the first word and the software enable
  function automatic logic [10:0] exp_wdt(input logic [31:0] w, input logic sw);
    logic [2:0] win;
    int         ps;
    win = (w[25:24] == 2'h3) ? 3'h2 : (w[25:24] == 2'h2) ? 3'h3 :
          (w[25:24] == 2'h1) ? 3'h4 : 3'h6;
    ps = (w[20:16] > 5'h14) ? 20 : int'(w[20:16]);
    return {w[23] | sw, w[23], ~w[22], win, 5'(ps)};
  endfunction : exp_wdt

  // clock decode from the first word
  function automatic logic [13:0] exp_clk(input logic [31:0] w);
    int div;
    div = 1 << w[13:12];
    return {w[2:0], w[9:8], w[7], w[5], ~w[15], w[15:14] == 2'h0, 4'(div),
            ~w[10] & (w[9:8] == 2'h3 || w[9:8] == 2'h0)};
  endfunction : exp_clk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  // every code of the two- and three-bit fields across eight loads, postscale in steps of 4
  initial
  begin
    {presetn, psel, penable, pwrite, pin_req, mod_req} = '0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    raw1 = 32'h00000000;
    raw3 = 32'h00000000;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(99960));
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom;
      r[25:24] = i[1:0];
      r[20:16] = 5'(i * 4);
      r[15:14] = i[1:0];
      r[13:12] = i[1:0];
      r[9:8] = i[1:0];
      r[2:0] = i[2:0];
      @(posedge pclk);
      presetn <= 1'b0;
      raw1 <= r;
      raw3 <= $urandom;
      repeat (4) @(posedge pclk);
      chk(32'(cfg_loaded), 32'h0);
      chk(32'(pin_cfg), 32'h0);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      r = nv1;
      chk(32'(wdt_cfg), 32'(exp_wdt(r, 1'b0)));
      chk(32'(clk_cfg), 32'(exp_clk(r)));
      chk(32'(pin_cfg), {28'h0, nv3[31:30], 2'h3});
      chk(32'(uid), {16'h0, nv3[15:0]});
      chk(32'(cfg_loaded), 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk(q, nv3 & 32'hF000FFFF);
      chk(32'(e), 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(q, r);
      apb(1'b1, 8'h00, ~r);
      chk(32'(e), 32'h1);
      raw1 <= ~raw1;
      raw3 <= ~raw3;
      apb(1'b1, 8'h08, 32'h1);
      chk(32'(e), 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h1);
      repeat (2) @(posedge pclk);
      chk(32'(wdt_cfg), 32'(exp_wdt(r, 1'b1)));
      apb(1'b1, 8'h08, 32'h0);
      repeat (2) @(posedge pclk);
      chk(32'(wdt_cfg.enable), 32'(r[23]));
      chk(32'(uid), {16'h0, ~nv3[15:0]});
      chk(32'(clk_cfg), 32'(exp_clk(r)));
      pin_req <= 1'b1;
      mod_req <= 1'b1;
      @(posedge pclk);
      pin_req <= 1'b0;
      mod_req <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(pin_cfg.pps_write_ok), 32'(nv3[29]));
      chk(32'(pin_cfg.pmd_write_ok), 32'(nv3[28]));
      apb(1'b0, 8'h0C, 32'h0);
      chk(q, {28'h0, ~nv3[28], ~nv3[29], r[23], 1'b1});
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(e), 32'h1);
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule : tb
`default_nettype wire
